// ==== pscc_top.sv ====
// power saving clock control: cpu wait gate, bus auto-slow, converter setup
//
// Functional notes
// - wait enable set: processor clock stopped while core idles awaiting interrupt
// - auto-slow active: bus clock lowered when no selected activity present
// - each of eight monitored activity kinds has its own enable
// - slowed bus clock is divided by the slow divider field value, 0 taken as 1
// - auto-slow applies only while the auto-slow enable is 1
// - small enable drops half the switches, large enable adds extra switches
// - both clear gives normal size; both set is a distinct state
// - pulse frequency enable puts converter into pulse frequency modulation
`timescale 1ns/1ps
`include "pscc_cfg.svh"

module pscc_top
  import pscc_pkg::*;
(
  input  wire logic                   mclk,                 // 40 MHz clock
  input  wire logic                   reset_n,              // async reset, active low
  input  wire logic                   clkEnable,            // freezes all state when low
  // processor wait gate
  input  wire logic                   waitIrqEn,            // interrupt wait enable
  input  wire logic                   cpuWaitReq,           // core executed wait, pulse
  input  wire logic                   irqPending,           // any interrupt pending
  output logic                        cpuClkEn,             // processor clock enable
  // bus auto-slow configuration
  input  wire logic                   autoSlowEn,           // auto-slow mode enable
  input  wire logic [`PSCC_DIV_W-1:0] slowDiv,              // extra bus divide ratio
  input  wire logic                   slowMonCryptoEn,      // watch crypto coprocessor
  input  wire logic                   slowMonPixelEn,       // watch pixel pipeline
  input  wire logic                   slowMonDmaAEn,        // watch peripheral dma a
  input  wire logic                   slowMonDmaBEn,        // watch peripheral dma b
  input  wire logic                   slowMonAnyMasterEn,   // watch any bus master
  input  wire logic                   slowMonFewMastersEn,  // watch under three masters
  input  wire logic                   slowMonCpuDataEn,     // watch cpu data access
  input  wire logic                   slowMonCpuFetchEn,    // watch cpu instruction fetch
  // bus activity indications
  input  wire logic                   actCrypto,            // crypto coprocessor busy
  input  wire logic                   actPixel,             // pixel pipeline busy
  input  wire logic                   actDmaA,              // peripheral dma a busy
  input  wire logic                   actDmaB,              // peripheral dma b busy
  input  wire logic                   actAnyMaster,         // any master on the bus
  input  wire logic                   actFewMasters,        // fewer than three masters
  input  wire logic                   actCpuData,           // cpu data access
  input  wire logic                   actCpuFetch,          // cpu instruction fetch
  output logic                        busClkEn,             // system bus clock enable
  output logic                        busSlowed,            // bus runs divided
  // converter configuration
  input  wire logic                   switchSizeSmallEn,    // half switch size enable
  input  wire logic                   switchSizeLargeEn,    // double switch size enable
  input  wire logic                   converterPulseFreqEn, // pulse frequency mode enable
  output logic                        switchHalfOff,        // half the switches off
  output logic                        switchExtraOn,        // extra switches on
  output pscc_fet_size_t              switchSize,           // decoded switch size
  output logic                        converterPfm          // converter in pulse mode
);

  // ==========================================================
  // processor wait gate
  pscc_cpu_state_t cpuState_r;
  pscc_cpu_state_t cpuState_nxt;
  logic            cpuClkEn_r;
  logic            cpuClkEn_nxt;

  // a pending interrupt at the wait request keeps the core running,
  // otherwise the wakeup would be missed until the next interrupt
  always_comb begin
    cpuState_nxt = cpuState_r;
    case (cpuState_r)
      PSCC_CPU_RUN: begin
        if (waitIrqEn && cpuWaitReq && !irqPending) begin
          cpuState_nxt = PSCC_CPU_WAIT;
        end
      end
      PSCC_CPU_WAIT: begin
        if (irqPending || !waitIrqEn) begin
          cpuState_nxt = PSCC_CPU_RUN;
        end
      end
      default: begin
        cpuState_nxt = PSCC_CPU_RUN;
      end
    endcase
    cpuClkEn_nxt = (cpuState_nxt == PSCC_CPU_RUN);
  end

  // registers only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpuState_r <= PSCC_CPU_RUN;
      cpuClkEn_r <= 1'b1;
    end else if (clkEnable) begin
      cpuState_r <= cpuState_nxt;
      cpuClkEn_r <= cpuClkEn_nxt;
    end
  end

  assign cpuClkEn = cpuClkEn_r;

  // ==========================================================
  // bus activity monitor
  logic [`PSCC_NUM_MON-1:0] monEnable;
  logic [`PSCC_NUM_MON-1:0] monActive;
  logic [`PSCC_NUM_MON-1:0] monHit;
  logic                     anyHit;

  assign monEnable[`PSCC_MON_CRYPTO]    = slowMonCryptoEn;
  assign monEnable[`PSCC_MON_PIXEL]     = slowMonPixelEn;
  assign monEnable[`PSCC_MON_DMA_A]     = slowMonDmaAEn;
  assign monEnable[`PSCC_MON_DMA_B]     = slowMonDmaBEn;
  assign monEnable[`PSCC_MON_ANY_MST]   = slowMonAnyMasterEn;
  assign monEnable[`PSCC_MON_FEW_MST]   = slowMonFewMastersEn;
  assign monEnable[`PSCC_MON_CPU_DATA]  = slowMonCpuDataEn;
  assign monEnable[`PSCC_MON_CPU_FETCH] = slowMonCpuFetchEn;

  assign monActive[`PSCC_MON_CRYPTO]    = actCrypto;
  assign monActive[`PSCC_MON_PIXEL]     = actPixel;
  assign monActive[`PSCC_MON_DMA_A]     = actDmaA;
  assign monActive[`PSCC_MON_DMA_B]     = actDmaB;
  assign monActive[`PSCC_MON_ANY_MST]   = actAnyMaster;
  assign monActive[`PSCC_MON_FEW_MST]   = actFewMasters;
  assign monActive[`PSCC_MON_CPU_DATA]  = actCpuData;
  assign monActive[`PSCC_MON_CPU_FETCH] = actCpuFetch;

  for (genvar i = 0; i < `PSCC_NUM_MON; i++) begin : g_mon
    assign monHit[i] = monEnable[i] & monActive[i];
  end

  assign anyHit = |monHit;

  // ==========================================================
  // bus auto-slow decision and divider
  pscc_div_if divBus ();
  logic       busSlowed_r;
  logic       busSlowed_nxt;

  always_comb begin
    busSlowed_nxt = autoSlowEn && !anyHit;
  end

  // registers only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busSlowed_r <= 1'b0;
    end else if (clkEnable) begin
      busSlowed_r <= busSlowed_nxt;
    end
  end

  // request follows the decision directly so the full rate returns
  // one cycle after activity, not two
  assign divBus.slowReq  = busSlowed_nxt;
  assign divBus.divValue = slowDiv;

  pscc_slow_div u_slow_div (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clkEnable (clkEnable),
    .dv        (divBus.div)
  );

  assign busClkEn  = divBus.tick;
  assign busSlowed = busSlowed_r;

  // ==========================================================
  // converter switch size and pulse mode
  logic           halfOff_r;
  logic           halfOff_nxt;
  logic           extraOn_r;
  logic           extraOn_nxt;
  pscc_fet_size_t size_r;
  pscc_fet_size_t size_nxt;
  logic           pfm_r;
  logic           pfm_nxt;

  // both set is passed on as is; the two do not cancel
  always_comb begin
    halfOff_nxt = switchSizeSmallEn;
    extraOn_nxt = switchSizeLargeEn;
    case ({switchSizeLargeEn, switchSizeSmallEn})
      2'h0:    size_nxt = PSCC_FET_NORMAL;
      2'h1:    size_nxt = PSCC_FET_HALF;
      2'h2:    size_nxt = PSCC_FET_DOUBLE;
      default: size_nxt = PSCC_FET_BOTH;
    endcase
    pfm_nxt = converterPulseFreqEn;
  end

  // registers only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      halfOff_r <= 1'b0;
      extraOn_r <= 1'b0;
      size_r    <= PSCC_FET_NORMAL;
      pfm_r     <= 1'b0;
    end else if (clkEnable) begin
      halfOff_r <= halfOff_nxt;
      extraOn_r <= extraOn_nxt;
      size_r    <= size_nxt;
      pfm_r     <= pfm_nxt;
    end
  end

  assign switchHalfOff = halfOff_r;
  assign switchExtraOn = extraOn_r;
  assign switchSize    = size_r;
  assign converterPfm  = pfm_r;

endmodule // pscc_top

// ==== pscc_cfg.svh ====
// constants for the power saving clock control block
`ifndef PSCC_CFG_SVH
`define PSCC_CFG_SVH

// ==========================================================
// activity kinds watched by the bus auto-slow logic
`define PSCC_NUM_MON       8
`define PSCC_MON_CRYPTO    0
`define PSCC_MON_PIXEL     1
`define PSCC_MON_DMA_A     2
`define PSCC_MON_DMA_B     3
`define PSCC_MON_ANY_MST   4
`define PSCC_MON_FEW_MST   5
`define PSCC_MON_CPU_DATA  6
`define PSCC_MON_CPU_FETCH 7

// ==========================================================
// slow divider field
`define PSCC_DIV_W         5
`define PSCC_DIV_RESET     5'h01
`define PSCC_DIV_ONE       5'h01
`define PSCC_CNT_ZERO      5'h00

`endif

// ==== pscc_pkg.sv ====
// types shared by the power saving clock control modules
package pscc_pkg;

  // ==========================================================
  // processor clock gate states
  typedef enum logic [0:0] {
    PSCC_CPU_RUN,
    PSCC_CPU_WAIT
  } pscc_cpu_state_t;

  // ==========================================================
  // converter power switch size as seen by the analog side
  typedef enum logic [1:0] {
    PSCC_FET_NORMAL,
    PSCC_FET_HALF,
    PSCC_FET_DOUBLE,
    PSCC_FET_BOTH
  } pscc_fet_size_t;

endpackage

// ==== pscc_div_if.sv ====
// carrier between the top control and the slow bus divider
`timescale 1ns/1ps
`include "pscc_cfg.svh"

interface pscc_div_if;
  logic                   slowReq;   // divide the bus clock
  logic [`PSCC_DIV_W-1:0] divValue;  // extra divide ratio
  logic                   tick;      // registered bus clock enable

  // ==========================================================
  // control side and divider side
  modport ctrl (output slowReq, output divValue, input tick);
  modport div  (input slowReq, input divValue, output tick);
endinterface

// ==== pscc_slow_div.sv ====
// extra divider for the system bus clock enable
`timescale 1ns/1ps
`include "pscc_cfg.svh"

module pscc_slow_div
  import pscc_pkg::*;
(
  input  wire logic mclk,      // 40 MHz clock
  input  wire logic reset_n,   // async reset, active low
  input  wire logic clkEnable, // freezes state when low
  pscc_div_if.div   dv         // request, ratio and tick
);

  logic [`PSCC_DIV_W-1:0] count_r;
  logic [`PSCC_DIV_W-1:0] count_nxt;
  logic                   tick_r;
  logic                   tick_nxt;
  logic [`PSCC_DIV_W-1:0] lastCount;

  // ==========================================================
  // divide counter
  // ratio 0 is taken as 1 so the bus never stops outright
  always_comb begin
    lastCount = (dv.divValue == `PSCC_CNT_ZERO) ? `PSCC_CNT_ZERO
                                                : dv.divValue - `PSCC_DIV_ONE;
    count_nxt = `PSCC_CNT_ZERO;
    tick_nxt  = 1'b1;
    if (dv.slowReq) begin
      if (count_r >= lastCount) begin
        count_nxt = `PSCC_CNT_ZERO;
        tick_nxt  = 1'b1;
      end else begin
        count_nxt = count_r + `PSCC_DIV_ONE;
        tick_nxt  = 1'b0;
      end
    end
  end

  // registers only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= `PSCC_CNT_ZERO;
      tick_r  <= 1'b1;
    end else if (clkEnable) begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign dv.tick = tick_r;

endmodule // pscc_slow_div

// ==== pscc_monitor.sv ====
// assertion checker for the power saving clock control top
`timescale 1ns/1ps

module pscc_monitor
  import pscc_pkg::*;
(
  input wire logic           mclk,                 // clock
  input wire logic           reset_n,              // reset, low
  input wire logic           clkEnable,            // run
  input wire logic           waitIrqEn,            // wait enable
  input wire logic           cpuWaitReq,           // wait request
  input wire logic           irqPending,           // irq pending
  input wire logic           cpuClkEn,             // cpu clock on
  input wire logic           autoSlowEn,           // auto-slow on
  input wire logic [4:0]     slowDiv,              // slow ratio
  input wire logic           slowMonCpuFetchEn,    // fetch watch
  input wire logic           actCpuFetch,          // fetch busy
  input wire logic           busClkEn,             // bus tick
  input wire logic           busSlowed,            // bus divided
  input wire logic           switchSizeSmallEn,    // small size
  input wire logic           switchSizeLargeEn,    // large size
  input wire logic           converterPulseFreqEn, // pulse enable
  input wire logic           switchHalfOff,        // half off
  input wire logic           switchExtraOn,        // extra on
  input wire pscc_fet_size_t switchSize,           // size code
  input wire logic           converterPfm          // pulse mode
);
  // ==========================================================
  // one clock domain, so one default clocking and disable
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  AST_WAIT_STOP: assert property (
    clkEnable && cpuClkEn && waitIrqEn && cpuWaitReq && !irqPending |=> !cpuClkEn)
    else $error("cpu clock not stopped on wait");
  AST_WAIT_HOLD: assert property (
    !cpuClkEn && waitIrqEn && !irqPending |=> !cpuClkEn)
    else $error("cpu clock woke without cause");
  AST_WAKE: assert property (
    clkEnable && !cpuClkEn && (irqPending || !waitIrqEn) |=> cpuClkEn)
    else $error("cpu clock not restored");
  AST_REFUSE: assert property (
    clkEnable && cpuClkEn && irqPending |=> cpuClkEn)
    else $error("cpu gated with interrupt pending");
  AST_NO_SLOW: assert property (
    clkEnable && !autoSlowEn |=> !busSlowed && busClkEn)
    else $error("bus slowed while auto-slow off");
  AST_RESTORE: assert property (
    clkEnable && slowMonCpuFetchEn && actCpuFetch |=> busClkEn && !busSlowed)
    else $error("bus not restored on activity");
  AST_DIV_GAP: assert property (
    clkEnable && busSlowed && busClkEn && slowDiv == 5'h02 |=> !busClkEn || !busSlowed)
    else $error("bus tick too close when divided");
  AST_DIV_TICK: assert property (
    clkEnable && busSlowed && !busClkEn && slowDiv == 5'h02 |=> busClkEn)
    else $error("bus tick missing when divided");
  AST_SIZE_COPY: assert property (
    clkEnable |=> switchHalfOff == $past(switchSizeSmallEn)
                  && switchExtraOn == $past(switchSizeLargeEn))
    else $error("switch size outputs wrong");
  AST_SIZE_CODE: assert property (
    switchSize == {switchExtraOn, switchHalfOff})
    else $error("switch size code wrong");
  AST_PFM: assert property (
    clkEnable |=> converterPfm == $past(converterPulseFreqEn))
    else $error("pulse mode output wrong");
endmodule // pscc_monitor

bind pscc_top pscc_monitor mon_u (.mclk(mclk), .reset_n(reset_n), .clkEnable(clkEnable),
  .waitIrqEn(waitIrqEn), .cpuWaitReq(cpuWaitReq), .irqPending(irqPending), .cpuClkEn(cpuClkEn),
  .autoSlowEn(autoSlowEn), .slowDiv(slowDiv), .slowMonCpuFetchEn(slowMonCpuFetchEn),
  .actCpuFetch(actCpuFetch), .busClkEn(busClkEn), .busSlowed(busSlowed),
  .switchSizeSmallEn(switchSizeSmallEn), .switchSizeLargeEn(switchSizeLargeEn),
  .converterPulseFreqEn(converterPulseFreqEn), .switchHalfOff(switchHalfOff),
  .switchExtraOn(switchExtraOn), .switchSize(switchSize), .converterPfm(converterPfm));

// ==== pscc_bench.sv ====
// self-checking bench for the power saving clock control block
`timescale 1ns/1ps
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("MISMATCH %0t check failed at line %0d", $time, `__LINE__); \
  end \
end

module pscc_bench;
  logic       mclk = 1'h0;
  logic       reset_n, clkEnable, waitIrqEn, cpuWaitReq, irqPending, autoSlowEn;
  logic       swSmall, swLarge, pfmEn;
  logic [4:0] slowDiv;
  logic [7:0] monEn, act;
  logic       cpuClkEn, busClkEn, busSlowed, halfOff, extraOn, pfmOut;
  logic [1:0] sizeOut;
  int         n_errors = 0, num_checks = 0, cnt;

  // ==========================================================
  // clock at 40 MHz
  always #12.5 mclk = ~mclk;

  pscc_top dut_u (.mclk(mclk), .reset_n(reset_n), .clkEnable(clkEnable),
    .waitIrqEn(waitIrqEn), .cpuWaitReq(cpuWaitReq), .irqPending(irqPending), .cpuClkEn(cpuClkEn),
    .autoSlowEn(autoSlowEn), .slowDiv(slowDiv), .slowMonCryptoEn(monEn[0]),
    .slowMonPixelEn(monEn[1]), .slowMonDmaAEn(monEn[2]), .slowMonDmaBEn(monEn[3]),
    .slowMonAnyMasterEn(monEn[4]), .slowMonFewMastersEn(monEn[5]),
    .slowMonCpuDataEn(monEn[6]), .slowMonCpuFetchEn(monEn[7]), .actCrypto(act[0]),
    .actPixel(act[1]), .actDmaA(act[2]), .actDmaB(act[3]), .actAnyMaster(act[4]),
    .actFewMasters(act[5]), .actCpuData(act[6]), .actCpuFetch(act[7]),
    .busClkEn(busClkEn), .busSlowed(busSlowed), .switchSizeSmallEn(swSmall),
    .switchSizeLargeEn(swLarge), .converterPulseFreqEn(pfmEn), .switchHalfOff(halfOff),
    .switchExtraOn(extraOn), .switchSize(sizeOut), .converterPfm(pfmOut));

  // wait edges, then sample once registered outputs settle
  task automatic tk(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ==========================================================
  // cpu wait gate: refusal, gating, wake by irq and by disable
  task automatic t_wait;
    @(posedge mclk);
    {waitIrqEn, irqPending, cpuWaitReq} <= 3'h7;
    tk(1);
    `CHK(cpuClkEn, 1'h1)
    @(posedge mclk);
    irqPending <= 1'h0;
    tk(1);
    `CHK(cpuClkEn, 1'h0)
    @(posedge mclk);
    cpuWaitReq <= 1'h0;
    tk(4);
    `CHK(cpuClkEn, 1'h0)
    @(posedge mclk);
    irqPending <= 1'h1;
    tk(1);
    `CHK(cpuClkEn, 1'h1)
    @(posedge mclk);
    {irqPending, cpuWaitReq} <= 2'h1;
    tk(1);
    `CHK(cpuClkEn, 1'h0)
    @(posedge mclk);
    waitIrqEn <= 1'h0;
    tk(2);
    `CHK(cpuClkEn, 1'h1)
    @(posedge mclk);
    cpuWaitReq <= 1'h0;
  endtask

  // ==========================================================
  // bus auto-slow: ratio, each kind alone, restore, disable
  task automatic t_slow;
    // ratios 0 to 3, 0 runs like 1
    for (int d = 0; d <= 3; d++) begin
      @(posedge mclk);
      {monEn, act, autoSlowEn, slowDiv} <= {8'hFF, 8'h00, 1'h1, 5'(d)};
      tk(1);
      `CHK(busSlowed, 1'h1)
      cnt = 0;
      repeat (6) begin
        tk(1);
        cnt += int'(busClkEn === 1'h1);
      end
      `CHK(cnt, (d == 0) ? 6 : 6 / d)
      @(posedge mclk);
      act <= 8'h80;
      tk(1);
      `CHK(busClkEn, 1'h1)
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      {monEn, act} <= {8'h01 << k, ~(8'h01 << k)};
      tk(1);
      `CHK(busSlowed, 1'h1)
      @(posedge mclk);
      act <= 8'h01 << k;
      tk(1);
      `CHK(busSlowed, 1'h0)
      `CHK(busClkEn, 1'h1)
    end
    @(posedge mclk);
    {autoSlowEn, act} <= 9'h000;
    tk(3);
    `CHK(busSlowed, 1'h0)
  endtask

  // ==========================================================
  // converter setup, every combination, then a frozen clock
  task automatic t_conv;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      {swLarge, swSmall} <= 2'h0;
      // pulse mode with bus quiet
      // both set only to prove the distinct size code
      @(posedge mclk);
      {pfmEn, swLarge, swSmall} <= 3'(i);
      tk(1);
      `CHK({extraOn, halfOff}, 2'(i))
      `CHK(sizeOut, 2'(i))
      `CHK(pfmOut, 1'(i >> 2))
    end
    @(posedge mclk);
    {clkEnable, pfmEn} <= 2'h0;
    tk(2);
    `CHK(pfmOut, 1'h1)
    // frozen state must hold the pending change until the clock returns
    @(posedge mclk);
    {clkEnable, swLarge, swSmall} <= 3'h4;
    tk(1);
    `CHK(pfmOut, 1'h0)
  endtask

  // single exit point for the run
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence after a 16 cycle reset
  initial begin
    {reset_n, waitIrqEn, cpuWaitReq, irqPending, autoSlowEn} = 5'h00;
    {swSmall, swLarge, pfmEn, monEn, act} = 19'h00000;
    clkEnable = 1'h1;
    slowDiv = 5'h01;
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    tk(2);
    `CHK({cpuClkEn, busClkEn, busSlowed}, 3'h6)
    t_wait;
    t_slow;
    t_conv;
    print_verdict;
  end

  // hang guard, counted as a mismatch
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
endmodule // pscc_bench
